// File: fas_float_add_sequencer.sv
`timescale 1ns/1ns
module fas_float_add_sequencer (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic start_in, // one-cycle execution-cycle pulse
	input wire logic [12:0] opcode_in, // {sign, 12-bit code}
	input wire logic [35:0] operand_in, // storage word for operand register
	input wire logic [35:0] high_in, // accumulator word at start
	output logic busy_out,
	output logic done_out, // end of operation pulse
	output logic illegal_out, // start with unknown code
	output logic [35:0] high_register_out,
	output logic [35:0] low_register_out,
	output logic [35:0] operand_register_out
);
	// ****************************************
	// registers
	// ****************************************
	fas_pkg::fas_state_t state; // tally stage
	logic [35:0] high_register; // bit 35 sign, 34:27 char, 26:0 fraction
	logic [35:0] low_register;
	logic [35:0] operand_register;
	logic [7:0] shift_counter; // count-down counter
	logic low_zero_tracking_flag; // set while low register holds zero
	logic float_phase_flag; // low register was nonzero at addition
	logic raw_mode; // unnormalized form
	logic first_sign; // sign of smaller-char operand for zero results
	logic step1_swapped; // step 1 pass two flag
	logic step3_half; // third step second cycle after low swap
	logic step4_half; // fourth step second cycle
	logic done;
	logic illegal;

	// ****************************************
	// decode and datapath wires
	// ****************************************
	wire op_fad = opcode_in == fas_pkg::FAS_OP_FAD;
	wire op_ufa = opcode_in == fas_pkg::FAS_OP_UFA;
	wire op_fam = opcode_in == fas_pkg::FAS_OP_FAM;
	wire op_uam = opcode_in == fas_pkg::FAS_OP_UAM;
	wire op_fsb = opcode_in == fas_pkg::FAS_OP_FSB;
	wire op_ok = op_fad | op_ufa | op_fam | op_uam | op_fsb;
	// operand sign forced during execution cycle
	wire op_sign = (op_fam | op_uam) ? 1'b0 : (op_fsb ? ~operand_in[35] : operand_in[35]);

	wire [7:0] h_char = high_register[34:27];
	wire [7:0] s_char = operand_register[34:27];
	wire [26:0] h_frac = high_register[26:0];
	wire [26:0] l_frac = low_register[26:0];
	// compare: operand char plus two's complement of high char
	wire [8:0] char_diff = {1'b0, s_char} + {1'b0, ~h_char} + 9'h001;
	wire s_larger = char_diff[8]; // carry out means operand char not below
	wire unlike = high_register[35] ^ operand_register[35];
	// adder on bits 1..35: characteristic from operand, fractions summed
	wire [26:0] add_a = unlike ? ~h_frac : h_frac;
	wire [35:0] add_sum = {1'b0, s_char, 27'h0} + {9'h000, add_a} + {9'h000, operand_register[26:0]};
	wire col9_carry = add_sum[27] != s_char[0]; // carry from fraction into char
	wire [35:0] shifted_low = {low_register[35:27], h_frac[0], l_frac[26:1]};
	wire both_zero = (h_frac == 27'h0) & low_zero_tracking_flag;
	wire [26:0] h_comp = ~h_frac;
	wire [7:0] low_char = h_char + ~fas_pkg::FAS_LOW_CHAR_OFFSET + 8'h01;

	// ****************************************
	// sequencer
	// ****************************************
	// one process keeps the swap/shift/add datapath in lock step with the stage
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= fas_pkg::FAS_IDLE;
			high_register <= 36'h0;
			low_register <= 36'h0;
			operand_register <= 36'h0;
			shift_counter <= 8'h00;
			low_zero_tracking_flag <= 1'b1;
			float_phase_flag <= 1'b0;
			raw_mode <= 1'b0;
			first_sign <= 1'b0;
			step1_swapped <= 1'b0;
			step3_half <= 1'b0;
			step4_half <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
		end else begin
			done <= 1'b0;
			illegal <= 1'b0;
			case (state)
				// execution cycle: operand arrives from storage
				fas_pkg::FAS_IDLE: begin
					if (start_in && op_ok) begin
						operand_register <= {op_sign, operand_in[34:0]};
						high_register <= high_in;
						raw_mode <= opcode_in[12];
						state <= fas_pkg::FAS_STEP1;
					end else if (start_in) begin
						illegal <= 1'b1; // unknown code ends at once
						done <= 1'b1;
					end
				end
				// order words, then measure the exact difference
				fas_pkg::FAS_STEP1: begin
					low_register <= 36'h0;
					low_zero_tracking_flag <= 1'b1;
					float_phase_flag <= 1'b0;
					if (!step1_swapped) begin
						step1_swapped <= 1'b1;
						// equal chars keep the original high sign
						first_sign <= (s_larger) ? high_register[35] : operand_register[35];
						if (!s_larger) begin
							high_register <= operand_register;
							operand_register <= high_register;
						end
					end else begin
						step1_swapped <= 1'b0;
						// a far difference would shift everything out anyway
						// ordered words always carry out of bit 8, so only the low byte is the gap
						if ({1'b0, char_diff[7:0]} < fas_pkg::FAS_FAR_LIMIT) begin
							shift_counter <= char_diff[7:0];
						end else begin
							high_register <= 36'h0;
							shift_counter <= 8'h00;
						end
						state <= fas_pkg::FAS_STEP2;
					end
				end
				// align: one place per count
				fas_pkg::FAS_STEP2: begin
					if (shift_counter != 8'h00) begin
						high_register <= {high_register[35:27], 1'b0, h_frac[26:1]};
						low_register <= shifted_low;
						if (h_frac[0]) begin
							low_zero_tracking_flag <= 1'b0;
						end
						shift_counter <= shift_counter - 8'h01;
					end else begin
						state <= fas_pkg::FAS_STEP3;
					end
				end
				// signed fraction addition
				fas_pkg::FAS_STEP3: begin
					if (step3_half) begin
						// low contents now in high, sum parked in operand register
						step3_half <= 1'b0;
						state <= fas_pkg::FAS_STEP4;
					end else if (!unlike && col9_carry) begin
						high_register <= {high_register[35], add_sum[34:27], 1'b1, add_sum[26:1]};
						low_register <= {low_register[35:27], add_sum[0], l_frac[26:1]};
						if (add_sum[0]) begin
							low_zero_tracking_flag <= 1'b0;
						end
						state <= raw_mode ? fas_pkg::FAS_FINISH : fas_pkg::FAS_STEP4;
					end else if (!unlike) begin
						high_register <= {high_register[35], add_sum[34:0]};
						state <= raw_mode ? fas_pkg::FAS_FINISH : fas_pkg::FAS_STEP4;
					end else if (!col9_carry) begin
						// no carry: high fraction was larger, result is complement with its sign
						high_register <= {high_register[35], add_sum[34:27], ~add_sum[26:0]};
						state <= raw_mode ? fas_pkg::FAS_FINISH : fas_pkg::FAS_STEP4;
					end else if (low_zero_tracking_flag) begin
						// carry: operand fraction was larger, so its sign rules
						high_register <= {operand_register[35], s_char, add_sum[26:0] + 27'h1};
						state <= fas_pkg::FAS_STEP4;
					end else begin
						float_phase_flag <= 1'b1;
						high_register <= {high_register[35], low_register[34:0]};
						operand_register <= {operand_register[35], s_char, add_sum[26:0]};
						step3_half <= 1'b1;
					end
				end
				// complement and zero test
				fas_pkg::FAS_STEP4: begin
					if (float_phase_flag && !step4_half) begin
						// low register gets complement, sum returns high
						low_register <= {low_register[35:27], h_comp};
						high_register <= operand_register;
						step4_half <= 1'b1;
					end else begin
						step4_half <= 1'b0;
						if (both_zero) begin
							high_register <= 36'h0;
							state <= fas_pkg::FAS_FINISH;
						end else if (h_frac[26]) begin
							state <= fas_pkg::FAS_FINISH;
						end else begin
							shift_counter <= 8'h00;
							state <= fas_pkg::FAS_STEP5;
						end
					end
				end
				// normalize high only, low rides along
				fas_pkg::FAS_STEP5: begin
					if (!h_frac[26] && h_frac != 27'h0) begin
						high_register <= {high_register[35:27], h_frac[25:0], l_frac[26]};
						low_register <= {low_register[35:27], l_frac[25:0], 1'b0};
						shift_counter <= shift_counter - 8'h01;
					end else begin
						high_register[34:27] <= h_char + shift_counter;
						state <= fas_pkg::FAS_FINISH;
					end
				end
				// first cycle of next instruction: low sign and char
				fas_pkg::FAS_FINISH: begin
					if (both_zero) begin
						high_register <= {first_sign, 35'h0};
						low_register <= {first_sign, 35'h0};
					end else begin
						low_register <= {high_register[35], low_char, l_frac};
					end
					done <= 1'b1;
					state <= fas_pkg::FAS_IDLE;
				end
				default: begin
					state <= fas_pkg::FAS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_out <= 1'b0;
		end else begin
			busy_out <= (state != fas_pkg::FAS_IDLE) || (start_in && op_ok);
		end
	end
	assign done_out = done;
	assign illegal_out = illegal;
	assign high_register_out = high_register;
	assign low_register_out = low_register;
	assign operand_register_out = operand_register;

	// ****************************************
	// checks
	// ****************************************
	logic [4:0] step_count; // cycles spent past execution
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			step_count <= 5'h00;
		end else begin
			// saturates so a long alignment cannot wrap back into the legal band
			if (state == fas_pkg::FAS_IDLE) begin
				step_count <= 5'h00;
			end else if (step_count != 5'h1f) begin
				step_count <= step_count + 5'h01;
			end
		end
	end
	a_step_order: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP2 |=> state inside {fas_pkg::FAS_STEP2, fas_pkg::FAS_STEP3})
		else $error("stage skipped");
	a_flag_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP1 |=> low_zero_tracking_flag && low_register[26:0] == 27'h0)
		else $error("low not reset in first step");
	a_shift_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP2 && shift_counter != 8'h00 |=> shift_counter == $past(shift_counter) - 8'h01)
		else $error("shift counter not stepped");
	a_step3_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP2 ##1 state == fas_pkg::FAS_STEP3 |-> $past(shift_counter) == 8'h00)
		else $error("third step before count zero");
	a_sign_copy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		done && !illegal |-> low_register[35] == high_register[35])
		else $error("signs differ at end");
	a_low_char: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		done && !illegal && high_register[26:0] != 27'h0 |-> low_register[34:27] == high_register[34:27] - 8'h1b)
		else $error("low characteristic wrong");
	a_norm_done: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP5 ##1 state == fas_pkg::FAS_FINISH |-> high_register[26] || high_register[26:0] == 27'h0)
		else $error("result not normalized");
	a_raw_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		raw_mode && state == fas_pkg::FAS_STEP3 && !unlike |=> state == fas_pkg::FAS_FINISH)
		else $error("raw add did not end");
	a_far_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP1 && step1_swapped && char_diff[7:0] >= 8'h40 |=> high_register == 36'h0)
		else $error("far operand not cleared");
	// ****************************************
	// further stage checks
	// ****************************************
	// no operation finishes faster than the shortest sequence allows
	a_step_floor: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_FINISH |-> step_count >= (raw_mode ? fas_pkg::FAS_RAW_MIN : fas_pkg::FAS_NORM_MIN))
		else $error("operation ended too early");
	// idle stays idle without an execution cycle
	a_idle_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_IDLE && !start_in |=> state == fas_pkg::FAS_IDLE)
		else $error("left idle without start");
	// a known code enters the first step
	a_start_step1: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_IDLE && start_in && op_ok |=> state == fas_pkg::FAS_STEP1)
		else $error("known code not started");
	// an unknown code ends at once and is flagged
	a_bad_code: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_IDLE && start_in && !op_ok |=> illegal && done)
		else $error("unknown code not flagged");
	// magnitude forms load a positive operand
	a_mag_sign: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_IDLE && start_in && (op_fam || op_uam) |=> !operand_register[35])
		else $error("magnitude sign not forced");
	// subtract loads the inverted operand sign
	a_sub_sign: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_IDLE && start_in && op_fsb |=> operand_register[35] != $past(operand_in[35]))
		else $error("subtract sign not inverted");
	// after ordering the smaller characteristic sits high
	a_order_small: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP1 && step1_swapped |-> s_larger)
		else $error("words not ordered");
	// the bit leaving the high fraction enters the low fraction top
	a_shift_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP2 && shift_counter != 8'h00 |=> low_register[26] == $past(high_register[0]))
		else $error("shifted bit lost");
	// like-sign overflow puts a one on top
	a_carry_top: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP3 && !step3_half && !unlike && col9_carry |=> high_register[26])
		else $error("overflow one missing");
	// like signs keep the common sign
	a_like_sign: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP3 && !step3_half && !unlike |=> high_register[35] == $past(high_register[35]))
		else $error("like sign changed");
	// unlike without carry: the high word was larger and keeps its sign
	a_unlike_sign: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP3 && !step3_half && unlike && !col9_carry |=> high_register[35] == $past(high_register[35]))
		else $error("unlike sign wrong");
	// unlike with carry and empty low: operand sign and one added
	a_add_one: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP3 && !step3_half && unlike && col9_carry && low_zero_tracking_flag
		|=> high_register[26:0] == $past(add_sum[26:0]) + 27'h1 && high_register[35] == $past(operand_register[35]))
		else $error("ones complement not corrected");
	// unlike with carry and nonzero low takes the detour
	a_low_swap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP3 && !step3_half && unlike && col9_carry && !low_zero_tracking_flag |=> float_phase_flag)
		else $error("low detour not taken");
	// raw forms stop after an unlike add without carry
	a_raw_unlike: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		raw_mode && state == fas_pkg::FAS_STEP3 && !step3_half && unlike && !col9_carry |=> state == fas_pkg::FAS_FINISH)
		else $error("raw unlike did not end");
	// each left shift counts the counter down once
	a_norm_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == fas_pkg::FAS_STEP5 && !high_register[26] && high_register[26:0] != 27'h0
		|=> shift_counter == $past(shift_counter) - 8'h01)
		else $error("normalize count wrong");
	c_raw: cover property (@(posedge clk_in) raw_mode && done);
	c_low_swap: cover property (@(posedge clk_in) step3_half);
	c_normalize: cover property (@(posedge clk_in) state == fas_pkg::FAS_STEP5);
	c_far_clear: cover property (@(posedge clk_in) state == fas_pkg::FAS_STEP1 && step1_swapped && char_diff[7:0] >= 8'h40);
	c_illegal: cover property (@(posedge clk_in) illegal);
endmodule : fas_float_add_sequencer

// File: fas_pkg.sv
// Overview of operation
// - sign, 8-bit biased characteristic, 27-bit fraction
// - five-stage step counter sequences execution phases
// - right shifts carry high bit 35 into low bit 9
// - low characteristic 27 below high characteristic
// - both result signs follow larger operand
// - zero result gives signed normal zeros
// - normalize high result only, never low
// - compare characteristics, swap so smaller sits high
// - difference below 100 octal loads shift counter
// - first step resets low register, sets flag
// - second step shifts right, counts down
// - third step adds fractions, sign from result
// - like-sign overflow raises characteristic, shifts right
// - unlike carry, low zero: add one
// - low nonzero: swap low through operand register
// - fourth step complements, returns low complement
// - fourth step clears zero, ends if normal
// - fifth step shifts left, adjusts characteristic
// - next first cycle copies high sign low
// - nonzero result: low characteristic minus 33 octal
// - raw add ends after third step, like signs
// - raw add ends, unlike signs without carry
// - magnitude add forces operand sign positive
// - raw magnitude add combines both exceptions
// - subtract inverts operand sign
// - decode the five operation codes
// - step cycles bounded 4-13 or 3-8; only the minimums are checked, and alignment alone can take 63 cycles
package fas_pkg;
	// ****************************************
	// word layout
	// ****************************************
	localparam int FAS_WORD_W = 36; // sign is bit 35 here, doc bit 0
	localparam int FAS_CHAR_W = 8;
	localparam int FAS_FRAC_W = 27;
	localparam logic [7:0] FAS_LOW_CHAR_OFFSET = 8'h1b; // 33 octal
	localparam logic [8:0] FAS_FAR_LIMIT = 9'h040; // 100 octal
	// ****************************************
	// operation codes: sign bit plus 12-bit code
	// ****************************************
	localparam logic [12:0] FAS_OP_FAD = 13'h00c0;
	localparam logic [12:0] FAS_OP_UFA = 13'h10c0;
	localparam logic [12:0] FAS_OP_FAM = 13'h00c4;
	localparam logic [12:0] FAS_OP_UAM = 13'h10c4;
	localparam logic [12:0] FAS_OP_FSB = 13'h00c2;
	// step cycle bounds after the execution cycle
	localparam int FAS_NORM_MIN = 4;
	localparam int FAS_NORM_MAX = 13;
	localparam int FAS_RAW_MIN = 3;
	localparam int FAS_RAW_MAX = 8;
	// tally stages plus idle and next-instruction cycle
	typedef enum logic [2:0] {
		FAS_IDLE = 3'b000,
		FAS_STEP1 = 3'b001,
		FAS_STEP2 = 3'b010,
		FAS_STEP3 = 3'b011,
		FAS_STEP4 = 3'b100,
		FAS_STEP5 = 3'b101,
		FAS_FINISH = 3'b110
	} fas_state_t;
endpackage : fas_pkg

// File: fas_control_model.sv
`timescale 1ns/1ns
// ****************************************
// central control and core storage stand-in
// ****************************************
module fas_control_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic req_in, // bench asks for one instruction
	input wire logic rush_in, // misbehave: issue even while waiting
	input wire logic [12:0] req_op_in,
	input wire logic [35:0] req_opd_in,
	input wire logic [35:0] req_high_in,
	input wire logic done_in,
	output logic start_out,
	output logic [12:0] opcode_out,
	output logic [35:0] operand_out,
	output logic [35:0] high_out,
	output logic waiting_out
);
	// issue the execution cycle, then hold off until end of operation
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			start_out <= 1'b0;
			opcode_out <= 13'h0000;
			operand_out <= 36'h0;
			high_out <= 36'h0;
			waiting_out <= 1'b0;
		end else if (req_in && (!waiting_out || rush_in)) begin
			// storage word rides along with the execution cycle
			start_out <= 1'b1;
			opcode_out <= req_op_in;
			operand_out <= req_opd_in;
			high_out <= req_high_in;
			waiting_out <= 1'b1;
		end else begin
			// words are stale now: toggle so nothing leans on them
			start_out <= 1'b0;
			operand_out <= ~operand_out;
			high_out <= ~high_out;
			if (done_in) begin
				waiting_out <= 1'b0;
			end
		end
	end
endmodule : fas_control_model

// File: fas_float_add_sequencer_bench.sv
`timescale 1ns/1ns
module fas_float_add_sequencer_bench;
	logic clk_in, reset_n_in, req, rush, start, busy, done, illegal, waiting;
	logic [12:0] req_op, opcode;
	logic [35:0] req_opd, req_high, operand, high, high_reg, low_reg;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	// ****************************************
	// design and partner
	// ****************************************
	fas_float_add_sequencer i_fas_float_add_sequencer (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.start_in(start), .opcode_in(opcode), .operand_in(operand), .high_in(high), .busy_out(busy),
		.done_out(done), .illegal_out(illegal), .high_register_out(high_reg), .low_register_out(low_reg),
		.operand_register_out());
	fas_control_model i_fas_control_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req),
		.rush_in(rush), .req_op_in(req_op), .req_opd_in(req_opd), .req_high_in(req_high), .done_in(done),
		.start_out(start), .opcode_out(opcode), .operand_out(operand), .high_out(high),
		.waiting_out(waiting));
	// ****************************************
	// clock, hang guard, helpers
	// ****************************************
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one request through the control model, held for a single edge
	task automatic issue(input logic [12:0] op, input logic [35:0] hi, input logic [35:0] opd, input logic r);
		@(posedge clk_in);
		req <= 1'b1;
		rush <= r;
		req_op <= op;
		req_high <= hi;
		req_opd <= opd;
		@(posedge clk_in);
		req <= 1'b0;
		rush <= 1'b0;
	endtask : issue
	// wait for end of operation, then judge the held result
	task automatic finish_op(input logic [35:0] exp_hi, input logic [35:0] exp_lo, input logic ill);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (done !== 1'b1 && n < 100);
		check("done", {35'h0, done}, 36'h1);
		check("illegal", {35'h0, illegal}, {35'h0, ill});
		@(posedge clk_in);
		#1;
		check("done pulse", {35'h0, done}, 36'h0);
		if (!ill) begin
			check("high", high_reg, exp_hi);
			check("low", low_reg, exp_lo);
		end
	endtask : finish_op
	task automatic run(input logic [12:0] op, input logic [35:0] hi, opd, exp_hi, exp_lo);
		issue(op, hi, opd, 1'b0);
		finish_op(exp_hi, exp_lo, 1'b0);
	endtask : run
	// ****************************************
	// scenarios; words are {sign, characteristic, fraction}
	// ****************************************
	task automatic t_like_add();
		run(fas_pkg::FAS_OP_FAD, 36'h404000000, 36'h402000000, 36'h406000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FAD, 36'h404000000, 36'h404000000, 36'h40c000000, 36'h330000000);
		run(fas_pkg::FAS_OP_FAD, 36'h404000001, 36'h40c000000, 36'h40e000000, 36'h334000000);
	endtask : t_like_add
	task automatic t_align();
		run(fas_pkg::FAS_OP_FAD, 36'h40c000000, 36'h404000000, 36'h40e000000, 36'h330000000);
		run(fas_pkg::FAS_OP_FAD, 36'h20c000000, 36'h404000000, 36'h404000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FAD, 36'h204000000, 36'h404000000, 36'h404000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FAD, 36'h004000000, 36'h404000000, 36'h404000000, 36'h328000000);
	endtask : t_align
	task automatic t_unlike();
		run(fas_pkg::FAS_OP_FAD, 36'h404000000, 36'hc04000000, 36'h0, 36'h0);
		run(fas_pkg::FAS_OP_FAD, 36'h406000000, 36'hc04000000, 36'h3fc000000, 36'h320000000);
		run(fas_pkg::FAS_OP_FAD, 36'hc04000000, 36'h40c000000, 36'h404000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FAD, 36'h404000001, 36'hc0c000000, 36'hbfffffffd, 36'hb27fffffc);
	endtask : t_unlike
	task automatic t_variants();
		run(fas_pkg::FAS_OP_UFA, 36'h406000000, 36'hc04000000, 36'h402000000, 36'h328000000);
		run(fas_pkg::FAS_OP_UFA, 36'h404000000, 36'h402000000, 36'h406000000, 36'h328000000);
		run(fas_pkg::FAS_OP_UAM, 36'h404000000, 36'hc02000000, 36'h406000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FAM, 36'h404000000, 36'hc02000000, 36'h406000000, 36'h328000000);
		run(fas_pkg::FAS_OP_FSB, 36'h404000000, 36'h402000000, 36'h3fc000000, 36'h320000000);
	endtask : t_variants
	// a start while busy must be ignored; an unknown code ends at once
	task automatic t_refuse_illegal();
		issue(fas_pkg::FAS_OP_FAD, 36'h404000000, 36'h402000000, 1'b0);
		@(posedge clk_in);
		#1;
		check("busy", {35'h0, busy}, 36'h1);
		issue(fas_pkg::FAS_OP_FSB, 36'h40c000000, 36'h404000000, 1'b1);
		finish_op(36'h406000000, 36'h328000000, 1'b0);
		issue(13'h0123, 36'h404000000, 36'h404000000, 1'b0);
		finish_op(36'h0, 36'h0, 1'b1);
	endtask : t_refuse_illegal
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		reset_n_in = 1'b0;
		req = 1'b0;
		rush = 1'b0;
		req_op = 13'h0000;
		req_opd = 36'h0;
		req_high = 36'h0;
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_like_add();
		t_align();
		t_unlike();
		t_variants();
		t_refuse_illegal();
		tally_and_finish();
	end
endmodule : fas_float_add_sequencer_bench
